// *** src/asw_defines.svh ***
// timing and width constants for the asynchronous memory write controller
`ifndef ASW_DEFINES_SVH
`define ASW_DEFINES_SVH

`define ASW_CLK_PS              40000
// slowest grade figures in picoseconds, used so every grade is met
`define ASW_ADDR_TO_END_PS      9000
`define ASW_STROBE_WIDTH_ON_PS  12000
`define ASW_DATA_SETUP_PS       7000
`define ASW_STROBE_TO_FLOAT_PS  5000
`define ASW_DRIVE_OFF_FLOAT_PS  6000
`define ASW_READ_CYCLE_PS       12000
// least times round up, never below one cycle
`define ASW_CYC(ps) (((ps) + `ASW_CLK_PS - 1) / `ASW_CLK_PS)
`define ASW_STROBE_CYCLES  `ASW_CYC(`ASW_STROBE_WIDTH_ON_PS + `ASW_STROBE_TO_FLOAT_PS)
// one spare cycle of strobe low for margin, one more count to raise it
`define ASW_STROBE_LOW_CYCLES (`ASW_STROBE_CYCLES + 1)
`define ASW_STROBE_LOAD       (`ASW_STROBE_LOW_CYCLES + 1)
`define ASW_FLOAT_CYCLES   `ASW_CYC(`ASW_DRIVE_OFF_FLOAT_PS)
`define ASW_RECOVER_CYCLES `ASW_CYC(`ASW_READ_CYCLE_PS)
`define ASW_ADDR_W   19
`define ASW_DATA_W   8
`define ASW_CNT_W    4
`define ASW_CNT_ONE  4'h1

`endif

// *** src/asw_pkg.sv ***
// types for the asynchronous memory write controller
`default_nettype none
package asw_pkg;

	typedef enum logic [2:0] {
		ASW_IDLE    = 3'b000,
		ASW_FLOAT   = 3'b001,
		ASW_SETUP   = 3'b010,
		ASW_STROBE  = 3'b011,
		ASW_END     = 3'b100,
		ASW_RETAIN  = 3'b101,
		ASW_RECOVER = 3'b110
	} asw_state_t;

	// one write request from the user side
	typedef struct packed {
		logic [18:0] addr;
		logic [7:0]  data;
	} asw_req_t;

	// memory pins driven by the controller
	typedef struct packed {
		logic        select_n;
		logic        strobe_n;
		logic        drive_en_n;
		logic [18:0] addr;
	} asw_pins_t;

endpackage : asw_pkg
`default_nettype wire

// *** src/asw_write_ctrl.sv ***
// write controller driving an asynchronous 512k by 8 static memory
// ==========================================================
// How it works
// - pins settle as select falls, a cycle before strobe falls; raising one ends write
// - data and address held through the write-ending strobe edge
// - strobe low exceeds float time plus data setup with outputs on
// - address valid at least 9 ns before write end, slowest grade
// - address may change at the ending edge, zero hold
// - strobe low at least 12 ns while drive enable low
// - data driven at least 7 ns before write-ending edge
// - data released a cycle after the ending strobe edge, with select
// - bus not driven until drive enable off float time passed
`timescale 1ns/1ps
`default_nettype none
`include "asw_defines.svh"

module asw_write_ctrl (
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	input  wire logic                     req_valid,
	input  wire asw_pkg::asw_req_t        req,
	input  wire logic                     retain_req,
	output var  logic                     req_ready,
	output var  logic                     retain_ack,
	output var  asw_pkg::asw_pins_t       pins,
	input  wire logic [`ASW_DATA_W-1:0]   byte_data_bus_in,
	output var  logic [`ASW_DATA_W-1:0]   byte_data_bus_out,
	output var  logic                     byte_data_bus_oe_n
);

	// ==========================================================
	// state
	asw_pkg::asw_state_t       state_reg;
	logic [`ASW_CNT_W-1:0]     cnt_reg;
	logic                      prev_drive_on_reg;
	asw_pkg::asw_req_t         hold_reg;
	logic                      take;
	logic                      last_count;

	// the data bus input is unused: this block only writes
	logic unused_in;
	assign unused_in = ^byte_data_bus_in;

	// a request is taken only from idle, and retention outranks it
	assign take = (state_reg == asw_pkg::ASW_IDLE) && !retain_req
	              && req_valid;
	// every timed phase leaves on the last count of the one counter
	assign last_count = (cnt_reg == `ASW_CNT_ONE);

	// ==========================================================
	// sequencer
	// one write per request; every phase lasts whole clocks, so the
	// slow clock buys setup margin at the cost of bus throughput
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= asw_pkg::ASW_IDLE;
		end else begin
			unique case (state_reg)
			asw_pkg::ASW_IDLE: begin
				if (retain_req) begin
					state_reg <= asw_pkg::ASW_RETAIN;
				end else if (take && prev_drive_on_reg) begin
					// memory may still drive after enable went high
					state_reg <= asw_pkg::ASW_FLOAT;
				end else if (take) begin
					state_reg <= asw_pkg::ASW_SETUP;
				end
			end
			asw_pkg::ASW_FLOAT: begin
				if (last_count) begin
					state_reg <= asw_pkg::ASW_SETUP;
				end
			end
			asw_pkg::ASW_SETUP: begin
				// address and data stand a full cycle before strobe
				state_reg <= asw_pkg::ASW_STROBE;
			end
			asw_pkg::ASW_STROBE: begin
				// 40 ns clock covers 9 ns address and 7 ns data setup
				if (last_count) begin
					state_reg <= asw_pkg::ASW_END;
				end
			end
			asw_pkg::ASW_END: begin
				state_reg <= asw_pkg::ASW_IDLE;
			end
			asw_pkg::ASW_RETAIN: begin
				// select stays high for as long as retention is asked
				if (!retain_req) begin
					state_reg <= asw_pkg::ASW_RECOVER;
				end
			end
			asw_pkg::ASW_RECOVER: begin
				if (last_count) begin
					state_reg <= asw_pkg::ASW_IDLE;
				end
			end
			default: begin
				// an illegal code falls back to a quiet idle
				state_reg <= asw_pkg::ASW_IDLE;
			end
			endcase
		end
	end

	// ==========================================================
	// phase counter
	// one shared down counter times float, strobe and recovery; it
	// is loaded before a timed phase and counts down inside it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
		end else begin
			unique case (state_reg)
			asw_pkg::ASW_IDLE: begin
				// only the float wait reads this load
				cnt_reg <= `ASW_CNT_W'(`ASW_FLOAT_CYCLES);
			end
			asw_pkg::ASW_RETAIN: begin
				cnt_reg <= `ASW_CNT_W'(`ASW_RECOVER_CYCLES);
			end
			asw_pkg::ASW_SETUP: begin
				cnt_reg <= `ASW_CNT_W'(`ASW_STROBE_LOAD);
			end
			asw_pkg::ASW_FLOAT, asw_pkg::ASW_STROBE,
			asw_pkg::ASW_RECOVER: begin
				cnt_reg <= cnt_reg - `ASW_CNT_ONE;
			end
			asw_pkg::ASW_END: begin
				cnt_reg <= '0;
			end
			default: begin
				cnt_reg <= '0;
			end
			endcase
		end
	end

	// ==========================================================
	// request capture
	// the request is copied on the take edge, so the user side may
	// change req at once; the pins then come only from this copy
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold_reg <= '0;
		end else if (take) begin
			hold_reg <= req;
		end
	end

	// ==========================================================
	// memory control pins, all from flip-flops
	// select opens a cycle before strobe and closes a cycle after it,
	// so both strobe edges see a settled address
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pins <= '{select_n: 1'b1, strobe_n: 1'b1,
			          drive_en_n: 1'b1, addr: '0};
		end else begin
			// memory outputs kept off by holding drive enable high
			pins.drive_en_n <= 1'b1;
			unique case (state_reg)
			asw_pkg::ASW_SETUP: begin
				pins.addr     <= hold_reg.addr;
				pins.select_n <= 1'b0;
				pins.strobe_n <= 1'b1;
			end
			asw_pkg::ASW_STROBE: begin
				// low for every count but the last one
				pins.strobe_n <= last_count;
			end
			asw_pkg::ASW_END: begin
				// zero hold: select closes a cycle after strobe rose
				pins.select_n <= 1'b1;
			end
			default: begin
				// retention and idle keep select high
				pins.select_n <= 1'b1;
				pins.strobe_n <= 1'b1;
			end
			endcase
		end
	end

	// ==========================================================
	// write data drive
	// the bus is driven from select fall to a cycle past strobe rise,
	// which covers the data setup and the zero hold after the write
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			byte_data_bus_out  <= '0;
			byte_data_bus_oe_n <= 1'b1;
		end else begin
			unique case (state_reg)
			asw_pkg::ASW_SETUP: begin
				byte_data_bus_out  <= hold_reg.data;
				byte_data_bus_oe_n <= 1'b0;
			end
			asw_pkg::ASW_STROBE: begin
				byte_data_bus_oe_n <= 1'b0;
			end
			asw_pkg::ASW_END: begin
				byte_data_bus_oe_n <= 1'b1;
			end
			default: begin
				// the last byte stays put, only the driver lets go
				byte_data_bus_oe_n <= 1'b1;
			end
			endcase
		end
	end

	// ==========================================================
	// user handshake
	// ready falls on the edge a request is seen and rises only once
	// the sequencer is back in idle with nothing pending
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			req_ready  <= 1'b0;
			retain_ack <= 1'b0;
		end else begin
			req_ready  <= (state_reg == asw_pkg::ASW_IDLE) && !retain_req
			              && !req_valid;
			retain_ack <= (state_reg == asw_pkg::ASW_RETAIN);
		end
	end

	// ==========================================================
	// output drive history
	// remembers whether memory outputs were on; this block never
	// turns them on, so the float wait is kept only as a safeguard
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_drive_on_reg <= 1'b0;
		end else begin
			prev_drive_on_reg <= !pins.drive_en_n;
		end
	end

endmodule : asw_write_ctrl
`default_nettype wire

// *** tb/asw_mem_model.sv ***
// behavioural byte memory on the far side of the write controller
`timescale 1ns/1ps
`default_nettype none
module asw_mem_model (
	input	wire asw_pkg::asw_pins_t	pins,
	input	wire logic [7:0]	bus,
	output	wire logic	mem_drive,
	output	var asw_pkg::asw_req_t	last_wr,
	output	var logic	wr_evt = 1'b0
);
	// ====
	// storage
	logic [7:0] mem [int];
	logic wr_open = 1'b0;
	wire logic active = !pins.select_n && !pins.strobe_n;
	// store on whichever select or strobe edge ends the overlap; an
	// unknown level at power-up never counts as the end of a write
	always @(active) begin
		if (wr_open && active !== 1'b1) begin
			mem[pins.addr] = bus;
			last_wr = {pins.addr, mem[pins.addr]};
			wr_evt = ~wr_evt;
		end
		wr_open = (active === 1'b1);
	end
	// drive off at once, on again only 2 ns late
	assign #(2, 0) mem_drive = !pins.select_n
		&& !pins.drive_en_n && pins.strobe_n;
endmodule : asw_mem_model
`default_nettype wire

// *** tb/asw_write_ctrl_assertions.sv ***
// pin timing checks for the memory write controller
`timescale 1ns/1ps
`default_nettype none
module asw_write_ctrl_checker (
	input	wire logic	mclk,
	input	wire logic	reset_n,
	input	wire logic	req_valid,
	input	wire logic	retain_req,
	input	wire logic	req_ready,
	input	wire logic	retain_ack,
	input	wire asw_pkg::asw_pins_t	pins,
	input	wire logic [7:0]	byte_data_bus_out,
	input	wire logic	byte_data_bus_oe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ====
	// write cycle shape
	in_select_a: assert property (!pins.strobe_n |-> !pins.select_n)
		else $error("strobe without select");
	take_start_a: assert property (req_valid && req_ready && !retain_req
		|-> ##2 !pins.select_n) else $error("no start");
	strobe_setup_a: assert property ($fell(pins.strobe_n) |->
		!$past(pins.select_n) && !$past(byte_data_bus_oe_n)) else $error("setup");
	strobe_width_a: assert property ($fell(pins.strobe_n) |->
		!pins.strobe_n [*2] ##1 pins.strobe_n) else $error("width");
	write_hold_a: assert property (!pins.strobe_n || $rose(pins.strobe_n) |->
		$stable(pins.addr) && $stable(byte_data_bus_out)) else $error("moved");
	end_release_a: assert property ($rose(pins.strobe_n) |=>
		pins.select_n && byte_data_bus_oe_n) else $error("no release");
	no_read_a: assert property (pins.drive_en_n)
		else $error("outputs on");
	retain_off_a: assert property (retain_ack |-> pins.select_n)
		else $error("selected in retention");
	cover property ($rose(pins.strobe_n));
	cover property ($rose(retain_ack));
	cover property (req_valid && !req_ready);
endmodule : asw_write_ctrl_checker
bind asw_write_ctrl asw_write_ctrl_checker chk (.mclk(mclk),
	.reset_n(reset_n), .req_valid(req_valid), .retain_req(retain_req),
	.req_ready(req_ready), .retain_ack(retain_ack), .pins(pins),
	.byte_data_bus_out(byte_data_bus_out),
	.byte_data_bus_oe_n(byte_data_bus_oe_n));
`default_nettype wire

// *** tb/asw_write_ctrl_bench.sv ***
// self-checking bench for the memory write controller
`timescale 1ns/1ps
`default_nettype none
module asw_write_ctrl_bench;
	logic	mclk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, retain_req = 1'b0;
	logic	req_ready, retain_ack, oe_n, mem_drive, wr_evt;
	logic [7:0]	bus_out, bus;
	asw_pkg::asw_req_t	req = '0, last_wr, exp_q [$];
	asw_pkg::asw_pins_t	pins;
	int	n_errors = 0, cmp_count = 0, seed = 32'h6b5d;
	// ====
	// released bus shows the inverse of the last byte, never a held copy
	assign bus = !oe_n ? bus_out : ~bus_out;
	asw_write_ctrl dut (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
		.req(req), .retain_req(retain_req), .req_ready(req_ready),
		.retain_ack(retain_ack), .pins(pins), .byte_data_bus_in(bus),
		.byte_data_bus_out(bus_out), .byte_data_bus_oe_n(oe_n));
	asw_mem_model mem (.pins(pins), .bus(bus), .mem_drive(mem_drive),
		.last_wr(last_wr), .wr_evt(wr_evt));
	initial forever #20 mclk = ~mclk;
	// hang guard, ten times the expected run
	initial begin
		#80000;
		n_errors++;
		results();
	end
	task automatic results;
		$display("errors %0d checks %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic check(input string n, input logic [26:0] e, g);
		cmp_count++;
		if (e !== g) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : check
	task automatic wait_ready;
		for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge mclk) #1;
		check("req_ready", 1, req_ready);
	endtask : wait_ready
	// note the byte before it is taken, drop valid right after
	task automatic write_one(input logic [18:0] a, input logic [7:0] d);
		wait_ready();
		req = {a, d};
		exp_q.push_back(req);
		req_valid = 1'b1;
		@(posedge mclk) #1;
		req_valid = 1'b0;
	endtask : write_one
	// each stored byte is matched to the oldest note
	always @(wr_evt) if (reset_n === 1'b1) begin
		if (exp_q.size() == 0) begin
			n_errors++;
			$display("BAD write exp none got %h", last_wr);
		end else begin
			check("write", exp_q.pop_front(), last_wr);
		end
	end
	// sampled mid-cycle, clear of the edge that moves the pins
	always @(negedge mclk) if (mem_drive === 1'b1 && oe_n === 1'b0)
		check("bus clash", 0, 1);
	initial begin
		repeat (16) @(posedge mclk);
		#1 reset_n = 1'b1;
		wait_ready();
		// retention wins over a pending write, which follows on exit
		req = {19'h2a5a5, 8'hc3};
		exp_q.push_back(req);
		req_valid = 1'b1;
		retain_req = 1'b1;
		repeat (2) @(posedge mclk) #1;
		check("retain", 2'b11, {retain_ack, pins.select_n});
		retain_req = 1'b0;
		for (int i = 0; i < 20 && pins.select_n !== 1'b0; i++) @(posedge mclk) #1;
		req_valid = 1'b0;
		write_one(19'h7ffff, 8'h00);
		write_one(19'h00000, 8'hff);
		repeat (20) write_one(19'($random(seed)), 8'($random(seed)));
		for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge mclk);
		check("pending", 0, 27'(exp_q.size()));
		results();
	end
endmodule : asw_write_ctrl_bench
`default_nettype wire
